/* test/sdp_regs_assertions.sv */
`timescale 1ns/1ps
module sdp_regs_assertions
    import sdp_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic reg_rd, // read
    input wire logic reg_wr, // write
    input wire logic [7:0] reg_index, // index
    input wire logic [31:0] reg_wdata, // wdata
    input wire logic [31:0] reg_rdata, // rdata
    input wire logic reg_rvalid, // rvalid
    input wire logic [1:0] bus_width_state, // strap
    input wire logic irq_pin_polarity, // polarity
    input wire logic irq, // irq
    input wire logic [15:0] rx_mem_addr, // rx addr
    input wire logic [31:0] rx_mem_rdata, // rx data
    input wire logic tx_mem_we, // tx write
    input wire logic [31:0] tx_mem_wdata, // tx data
    input wire logic [15:0] tx_frame_length, // length
    input wire logic pointer_wrap_enable // wrap
);
    logic [2:0] step;
    logic port_wr;
    logic rx_rd;
    logic en_wr;
    assign en_wr = reg_wr && reg_index == OFF_IRQ_ENABLE;
    assign step = bus_width_state == SDP_BUS_32 ? STEP_32 :
        bus_width_state == SDP_BUS_16 ? STEP_16 : STEP_8;
    assign port_wr = reg_wr && (reg_index == OFF_TX_WRITE_HOLD ||
        reg_index == OFF_TX_WRITE_INCR);
    assign rx_rd = ce && reg_rd && reg_index == OFF_RX_READ_INCR;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rv; ce |=> reg_rvalid == $past(reg_rd); endproperty
    a_rv: assert property (p_rv)
        else $error("read valid wrong");
    property p_rxinc;
        rx_rd && !reg_wr && !pointer_wrap_enable
            |=> rx_mem_addr == $past(rx_mem_addr) + $past(step);
    endproperty
    a_rxinc: assert property (p_rxinc)
        else $error("read pointer step wrong");
    property p_rdata; rx_rd |=> reg_rdata == $past(rx_mem_rdata); endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data wrong");
    property p_we; ce |=> tx_mem_we == $past(port_wr); endproperty
    a_we: assert property (p_we)
        else $error("tx write pulse wrong");
    property p_txd;
        ce && port_wr |=> tx_mem_wdata == $past(reg_wdata);
    endproperty
    a_txd: assert property (p_txd)
        else $error("tx write data wrong");
    property p_hi;
        ce && reg_wr && reg_index == OFF_IRQ_ENABLE && reg_wdata[7] &&
            !pointer_wrap_enable |=> rx_mem_addr[15:8] == RX_WRAP_HIGH_BYTE;
    endproperty
    a_hi: assert property (p_hi)
        else $error("read high byte not loaded");
    property p_len;
        ce && reg_wr && reg_index == OFF_TX_LEN_LO
            |=> tx_frame_length[7:0] == $past(reg_wdata[7:0]);
    endproperty
    a_len: assert property (p_len)
        else $error("length low byte wrong");
    property p_wen;
        ce |=> pointer_wrap_enable == ($past(en_wr) ? $past(reg_wdata[7]) :
            $past(pointer_wrap_enable));
    endproperty
    a_wen: assert property (p_wen)
        else $error("wrap enable wrong");
    property p_rst;
        disable iff (1'b0) rst |=> !reg_rvalid && !tx_mem_we &&
            tx_frame_length == 16'h0000 && irq == $past(irq_pin_polarity);
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
endmodule

/* test/sdp_rx_mem_model.sv */
`timescale 1ns/1ps
module sdp_rx_mem_model (
    input wire logic [15:0] rx_mem_addr, // buffer address
    output logic [31:0] rx_mem_rdata // buffer data
);
    // data carries the address so each read is distinct
    assign rx_mem_rdata = {16'hA5A5, rx_mem_addr};
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench
    import sdp_pkg::*;
;
    typedef struct packed {logic [7:0] i, d, r, e;} sdp_row_s;
    logic clk, rst, ce, reg_rd, reg_wr, irq_pin_polarity;
    logic reg_rvalid, irq, tx_mem_we, pointer_wrap_enable;
    logic [7:0] reg_index, s;
    logic [31:0] reg_wdata, reg_rdata, rx_mem_rdata, tx_mem_wdata;
    logic [1:0] bus_width_state;
    logic [5:0] event_pulse;
    logic [15:0] rx_mem_addr, tx_mem_addr, tx_frame_length;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] st [4] = '{8'h02, 8'h04, 8'h01, 8'h01};
    sdp_row_s rows [10] = '{'{8'hF4, 8'h56, 8'h00, 8'h56},
        '{8'hF5, 8'h78, 8'h00, 8'h78}, '{8'hFA, 8'h9A, 8'h00, 8'h9A},
        '{8'hFB, 8'h0B, 8'h00, 8'h0B}, '{8'hFC, 8'h12, 8'h00, 8'h12},
        '{8'hFD, 8'h34, 8'h00, 8'h34}, '{8'hFF, 8'h7F, 8'h00, 8'h3F},
        '{8'hFE, 8'hFF, 8'h80, 8'h80}, '{8'hF0, 8'h55, 8'h00, 8'h00},
        '{8'hF6, 8'h66, 8'h00, 8'h00}};
    sdp_regs dut (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_index(reg_index),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .bus_width_state(bus_width_state),
        .event_pulse(event_pulse),
        .irq_pin_polarity(irq_pin_polarity),
        .irq(irq),
        .rx_mem_addr(rx_mem_addr),
        .rx_mem_rdata(rx_mem_rdata),
        .tx_mem_we(tx_mem_we),
        .tx_mem_addr(tx_mem_addr),
        .tx_mem_wdata(tx_mem_wdata),
        .tx_frame_length(tx_frame_length),
        .pointer_wrap_enable(pointer_wrap_enable)
    );
    sdp_rx_mem_model rxm (
        .rx_mem_addr(rx_mem_addr),
        .rx_mem_rdata(rx_mem_rdata)
    );
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_index = i;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        @(negedge clk);
        reg_rd = 1;
        reg_index = i;
        @(negedge clk);
        reg_rd = 0;
        chk(reg_rvalid, 1'h1);
        chk(reg_rdata, e);
    endtask
    task automatic do_reset(input logic [1:0] w);
        @(negedge clk);
        bus_width_state = w;
        irq_pin_polarity = 0;
        rst = 1;
        repeat (3) @(negedge clk);
        rst = 0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {rst, ce, reg_rd, reg_wr, reg_index, reg_wdata} = {2'h3, 42'h0};
        {event_pulse, irq_pin_polarity, bus_width_state} = 9'h002;
        do_reset(2'h2);
        for (int k = 0; k < 10; k++) begin
            rd(rows[k].i, rows[k].r);
            wr(rows[k].i, rows[k].d);
            rd(rows[k].i, rows[k].e);
        end
        ce = 0;
        wr(OFF_TX_LEN_LO, 8'hEE);
        ce = 1;
        rd(OFF_TX_LEN_LO, 8'h12);
        $display("table done");
        wr(OFF_IRQ_ENABLE, 8'h21);
        @(negedge clk);
        event_pulse = 6'h3F;
        @(negedge clk);
        event_pulse = 6'h00;
        repeat (2) @(negedge clk);
        chk(irq, 1'h1);
        rd(OFF_IRQ_STATUS, 8'hBF);
        wr(OFF_IRQ_STATUS, 8'h01);
        rd(OFF_IRQ_STATUS, 8'hBE);
        wr(OFF_IRQ_STATUS, 8'h20);
        @(negedge clk);
        chk(irq, 1'h0);
        irq_pin_polarity = 1;
        repeat (2) @(negedge clk);
        chk(irq, 1'h1);
        wr(OFF_IRQ_ENABLE, 8'h02);
        @(negedge clk);
        // frame sent still pending, active low pin goes to zero
        chk(irq, 1'h0);
        @(negedge clk);
        event_pulse = 6'h01;
        reg_wr = 1;
        reg_index = OFF_IRQ_STATUS;
        reg_wdata = 32'h0000_0001;
        @(negedge clk);
        event_pulse = 6'h00;
        reg_wr = 0;
        // event and write-one clear together, set wins
        rd(OFF_IRQ_STATUS, 8'h9F);
        $display("irq done");
        // host turns wrap on itself
        wr(OFF_IRQ_ENABLE, 8'h80);
        rd(OFF_RX_ADDR_HI, 8'h0C);
        wr(OFF_RX_ADDR_LO, 8'hFF);
        wr(OFF_RX_ADDR_HI, 8'h3F);
        rd(OFF_RX_READ_INCR, 32'hA5A5_3FFF);
        rd(OFF_RX_ADDR_LO, 8'h00);
        rd(OFF_RX_ADDR_HI, 8'h0C);
        wr(OFF_TX_ADDR_LO, 8'hFF);
        wr(OFF_TX_ADDR_HI, 8'h0B);
        wr(OFF_TX_WRITE_INCR, 8'h44);
        chk(tx_mem_addr, 16'h0BFF);
        rd(OFF_TX_ADDR_LO, 8'h00);
        rd(OFF_TX_ADDR_HI, 8'h00);
        $display("wrap done");
        for (int w = 0; w < 4; w++) begin
            do_reset(w[1:0]);
            s = st[w];
            wr(OFF_RX_ADDR_HI, 8'h10);
            rd(OFF_RX_READ_INCR, 32'hA5A5_1000);
            rd(OFF_RX_READ_INCR, {16'hA5A5, 16'h1000 + s});
            rd(OFF_RX_ADDR_LO, s + s);
            rd(OFF_IRQ_STATUS, {w[1:0], 6'h00});
            wr(OFF_TX_ADDR_LO, 8'h10);
            wr(OFF_TX_WRITE_HOLD, 8'h11);
            chk(tx_mem_we, 1'h1);
            chk(tx_mem_wdata, 8'h11);
            wr(OFF_TX_WRITE_INCR, 8'h22);
            chk(tx_mem_addr, 16'h0010);
            wr(OFF_TX_WRITE_INCR, 8'h33);
            chk(tx_mem_addr, 16'h0010 + s);
            rd(OFF_TX_ADDR_LO, 8'h10 + s + s);
            $display("width %0d done", w);
        end
        print_verdict();
    end
endmodule
bind sdp_regs sdp_regs_assertions u_chk (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_index(reg_index),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .bus_width_state(bus_width_state),
    .irq_pin_polarity(irq_pin_polarity),
    .irq(irq),
    .rx_mem_addr(rx_mem_addr),
    .rx_mem_rdata(rx_mem_rdata),
    .tx_mem_we(tx_mem_we),
    .tx_mem_wdata(tx_mem_wdata),
    .tx_frame_length(tx_frame_length),
    .pointer_wrap_enable(pointer_wrap_enable)
);

/* verilog/sdp_pkg.sv */
package sdp_pkg;

    // register indices on the indexed host bus
    localparam logic [7:0] OFF_RX_READ_INCR = 8'hF2;
    localparam logic [7:0] OFF_RX_ADDR_LO = 8'hF4;
    localparam logic [7:0] OFF_RX_ADDR_HI = 8'hF5;
    localparam logic [7:0] OFF_TX_WRITE_HOLD = 8'hF6;
    localparam logic [7:0] OFF_TX_WRITE_INCR = 8'hF8;
    localparam logic [7:0] OFF_TX_ADDR_LO = 8'hFA;
    localparam logic [7:0] OFF_TX_ADDR_HI = 8'hFB;
    localparam logic [7:0] OFF_TX_LEN_LO = 8'hFC;
    localparam logic [7:0] OFF_TX_LEN_HI = 8'hFD;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hFE;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'hFF;

    // status and enable field positions
    localparam int BIT_FRAME_RECEIVED = 0;
    localparam int BIT_FRAME_SENT = 1;
    localparam int BIT_RX_OVERFLOW = 2;
    localparam int BIT_COUNTER_WRAP = 3;
    localparam int BIT_TX_UNDERRUN = 4;
    localparam int BIT_LINK_CHANGE = 5;
    localparam int BIT_ENABLE_RSVD = 6;
    localparam int BIT_POINTER_WRAP = 7;
    localparam int BUS_WIDTH_LSB = 6;
    localparam int NUM_EVENTS = 6;

    // reset values
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] RST_LEN = 16'h0000;
    localparam logic [5:0] RST_FLAGS = 6'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [1:0] RST_BUS_WIDTH = 2'h0;

    // high byte forced into the read address when wrap is turned on
    localparam logic [7:0] RX_WRAP_HIGH_BYTE = 8'h0C;

    // buffer regions used by the wrap-around logic
    localparam logic [15:0] RX_BUF_START = 16'h0C00;
    localparam logic [15:0] RX_BUF_END = 16'h3FFF;
    localparam logic [15:0] TX_BUF_START = 16'h0000;
    localparam logic [15:0] TX_BUF_END = 16'h0BFF;

    // strapped bus width codes
    typedef enum logic [1:0] {
        SDP_BUS_16 = 2'b00,
        SDP_BUS_32 = 2'b01,
        SDP_BUS_8 = 2'b10,
        SDP_BUS_RSVD = 2'b11
    } sdp_bus_e;

    // pointer steps per access
    localparam logic [2:0] STEP_8 = 3'h1;
    localparam logic [2:0] STEP_16 = 3'h2;
    localparam logic [2:0] STEP_32 = 3'h4;

endpackage

/* verilog/sdp_ptr.sv */
`timescale 1ns/1ps
module sdp_ptr
    import sdp_pkg::*;
(
    input wire logic clk,               // system clock
    input wire logic rst,               // sync reset, active high
    input wire logic ce,                // clock enable
    input wire logic load_lo,           // host writes low byte
    input wire logic load_hi,           // host writes high byte
    input wire logic [7:0] load_val,    // host byte
    input wire logic force_hi,          // force high byte
    input wire logic [7:0] force_val,   // forced high byte value
    input wire logic advance,           // step the pointer
    input wire logic [2:0] step,        // step size in bytes
    input wire logic wrap_en,           // wrap inside region
    input wire logic [15:0] lo_bound,   // region start
    input wire logic [15:0] hi_bound,   // region end
    output logic [15:0] ptr             // current pointer
);

    logic [15:0] next_ptr;
    logic [16:0] sum;

    always_comb begin
        next_ptr = ptr;
        sum = {1'b0, ptr} + {14'h0000, step};
        if (advance) begin
            if (wrap_en && sum > {1'b0, hi_bound}) begin
                next_ptr = lo_bound + 16'(sum - {1'b0, hi_bound} - 17'd1);
            end else begin
                next_ptr = sum[15:0];
            end
        end
        if (load_lo) begin
            next_ptr[7:0] = load_val;
        end
        if (load_hi) begin
            next_ptr[15:8] = load_val;
        end
        if (force_hi) begin
            next_ptr[15:8] = force_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr <= RST_ADDR;
        end else if (ce) begin
            ptr <= next_ptr;
        end
    end

endmodule

/* verilog/sdp_regs.sv */
// What this block does
// - receive-data read returns data, advances pointer
// - enabling wrap loads read high byte 0Ch
// - read address byte pair, readable, resets zero
// - hold transmit write stores, pointer unchanged
// - incrementing transmit write stores, advances pointer
// - write address byte pair, readable, resets zero
// - sixteen-bit transmit length register, cleared reset
// - six status flags, each cleared writing one
// - six enable bits matching flags, reset zero
// - wrap enable wraps pointers inside buffer
// - polarity bit selects active low output
`timescale 1ns/1ps
module sdp_regs
    import sdp_pkg::*;
(
    input wire logic clk,                   // system clock, 200 MHz
    input wire logic rst,                   // sync reset, active high
    input wire logic ce,                    // clock enable
    input wire logic reg_rd,                // host read strobe
    input wire logic reg_wr,                // host write strobe
    input wire logic [7:0] reg_index,       // register index
    input wire logic [31:0] reg_wdata,      // host write data
    output logic [31:0] reg_rdata,          // host read data
    output logic reg_rvalid,                // read data valid pulse
    input wire logic [1:0] bus_width_state, // strapped bus width
    input wire logic [5:0] event_pulse,     // event set pulses
    input wire logic irq_pin_polarity,      // 1 makes irq active low
    output logic irq,                       // interrupt output
    output logic [15:0] rx_mem_addr,        // receive buffer address
    input wire logic [31:0] rx_mem_rdata,   // receive buffer data
    output logic tx_mem_we,                 // transmit buffer write
    output logic [15:0] tx_mem_addr,        // transmit buffer address
    output logic [31:0] tx_mem_wdata,       // transmit buffer data
    output logic [15:0] tx_frame_length,    // programmed frame length
    output logic pointer_wrap_enable        // wrap enable state
);

    logic [1:0] width;
    logic [5:0] flags;
    logic [7:0] irq_enable_reg;
    logic [15:0] rx_ptr;
    logic [15:0] tx_ptr;
    logic [2:0] step;

    logic [1:0] next_width;
    logic [5:0] next_flags;
    logic [7:0] next_irq_enable;
    logic [15:0] next_len;
    logic [31:0] next_rdata;
    logic next_rvalid;
    logic next_irq;
    logic next_tx_we;
    logic [15:0] next_tx_addr;
    logic [31:0] next_tx_wdata;

    logic wr_lo_rx;
    logic wr_hi_rx;
    logic wr_lo_tx;
    logic wr_hi_tx;
    logic rx_advance;
    logic tx_store;
    logic tx_advance;
    logic wrap_rise;
    logic [7:0] status_view;

    assign wr_lo_rx = reg_wr && reg_index == OFF_RX_ADDR_LO;
    assign wr_hi_rx = reg_wr && reg_index == OFF_RX_ADDR_HI;
    assign wr_lo_tx = reg_wr && reg_index == OFF_TX_ADDR_LO;
    assign wr_hi_tx = reg_wr && reg_index == OFF_TX_ADDR_HI;
    assign rx_advance = reg_rd && reg_index == OFF_RX_READ_INCR;
    assign tx_store = reg_wr && (reg_index == OFF_TX_WRITE_HOLD
        || reg_index == OFF_TX_WRITE_INCR);
    assign tx_advance = reg_wr && reg_index == OFF_TX_WRITE_INCR;
    assign wrap_rise = reg_wr && reg_index == OFF_IRQ_ENABLE
        && reg_wdata[BIT_POINTER_WRAP] && !irq_enable_reg[BIT_POINTER_WRAP];

    assign pointer_wrap_enable = irq_enable_reg[BIT_POINTER_WRAP];
    assign rx_mem_addr = rx_ptr;
    assign status_view = {width, flags};

    always_comb begin
        unique case (sdp_bus_e'(width))
            SDP_BUS_16: step = STEP_16;
            SDP_BUS_32: step = STEP_32;
            SDP_BUS_8: step = STEP_8;
            SDP_BUS_RSVD: step = STEP_8;
        endcase
    end

    sdp_ptr u_rx_ptr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load_lo(wr_lo_rx),
        .load_hi(wr_hi_rx),
        .load_val(reg_wdata[7:0]),
        .force_hi(wrap_rise),
        .force_val(RX_WRAP_HIGH_BYTE),
        .advance(rx_advance),
        .step(step),
        .wrap_en(pointer_wrap_enable),
        .lo_bound(RX_BUF_START),
        .hi_bound(RX_BUF_END),
        .ptr(rx_ptr)
    );

    sdp_ptr u_tx_ptr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load_lo(wr_lo_tx),
        .load_hi(wr_hi_tx),
        .load_val(reg_wdata[7:0]),
        .force_hi(1'b0),
        .force_val(RST_ENABLE),
        .advance(tx_advance),
        .step(step),
        .wrap_en(pointer_wrap_enable),
        .lo_bound(TX_BUF_START),
        .hi_bound(TX_BUF_END),
        .ptr(tx_ptr)
    );

    always_comb begin
        next_width = width;
        next_flags = flags;
        next_irq_enable = irq_enable_reg;
        next_len = tx_frame_length;
        if (reg_wr && reg_index == OFF_IRQ_STATUS) begin
            next_flags = flags & ~reg_wdata[NUM_EVENTS-1:0];
        end
        // set wins over clear
        next_flags = next_flags | event_pulse;
        if (reg_wr && reg_index == OFF_IRQ_ENABLE) begin
            next_irq_enable = reg_wdata[7:0];
            next_irq_enable[BIT_ENABLE_RSVD] = 1'b0;
        end
        if (reg_wr && reg_index == OFF_TX_LEN_LO) begin
            next_len[7:0] = reg_wdata[7:0];
        end
        if (reg_wr && reg_index == OFF_TX_LEN_HI) begin
            next_len[15:8] = reg_wdata[7:0];
        end
        next_irq = |(flags & irq_enable_reg[NUM_EVENTS-1:0]);
        next_irq = next_irq ^ irq_pin_polarity;
    end

    always_comb begin
        next_rvalid = reg_rd;
        next_rdata = reg_rdata;
        if (reg_rd) begin
            unique case (reg_index)
                OFF_RX_READ_INCR: next_rdata = rx_mem_rdata;
                OFF_RX_ADDR_LO: next_rdata = {24'h0000_00, rx_ptr[7:0]};
                OFF_RX_ADDR_HI: next_rdata = {24'h0000_00, rx_ptr[15:8]};
                OFF_TX_ADDR_LO: next_rdata = {24'h0000_00, tx_ptr[7:0]};
                OFF_TX_ADDR_HI: next_rdata = {24'h0000_00, tx_ptr[15:8]};
                OFF_TX_LEN_LO: begin
                    next_rdata = {24'h0000_00, tx_frame_length[7:0]};
                end
                OFF_TX_LEN_HI: begin
                    next_rdata = {24'h0000_00, tx_frame_length[15:8]};
                end
                OFF_IRQ_STATUS: next_rdata = {24'h0000_00, status_view};
                OFF_IRQ_ENABLE: begin
                    next_rdata = {24'h0000_00, irq_enable_reg};
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_tx_we = tx_store;
        next_tx_addr = tx_ptr;
        next_tx_wdata = reg_wdata;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // strap caught while reset is held
            width <= bus_width_state;
            flags <= RST_FLAGS;
            irq_enable_reg <= RST_ENABLE;
            tx_frame_length <= RST_LEN;
            irq <= irq_pin_polarity;
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
            tx_mem_we <= 1'b0;
            tx_mem_addr <= RST_ADDR;
            tx_mem_wdata <= 32'h0000_0000;
        end else if (ce) begin
            width <= next_width;
            flags <= next_flags;
            irq_enable_reg <= next_irq_enable;
            tx_frame_length <= next_len;
            irq <= next_irq;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
            tx_mem_we <= next_tx_we;
            tx_mem_addr <= next_tx_addr;
            tx_mem_wdata <= next_tx_wdata;
        end
    end

endmodule
